// ### rtl/sewg_pkg.sv
package sewg_pkg;

  // ****************************************************************
  // link timing
  // ****************************************************************
  localparam int SYS_CLK_MHZ   = 50;
  localparam int GLITCH_NS     = 20;
  // a pulse must outlast the glitch width, so round up to whole cycles
  localparam int GLITCH_CYC    = (GLITCH_NS * SYS_CLK_MHZ + 999) / 1000 < 1 ? 1 :
                                 (GLITCH_NS * SYS_CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int ADDR_W_DEF    = 8;
  localparam int DATA_W        = 16;
  localparam int OP_W          = 2;

  // ****************************************************************
  // opcode encodings (first two bits after the start bit)
  // ****************************************************************
  localparam logic [1:0] OP_EXT   = 2'h0;   // mode and chip-wide group
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // top two address bits select the member of the chip-wide group
  localparam logic [1:0] EXT_WRITE_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL     = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL     = 2'h2;
  localparam logic [1:0] EXT_WRITE_ENABLE  = 2'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    SEWG_K_NONE        = 3'h0,
    SEWG_K_WRITE       = 3'h1,
    SEWG_K_ERASE       = 3'h2,
    SEWG_K_WRITE_ALL   = 3'h3,
    SEWG_K_ERASE_ALL   = 3'h4,
    SEWG_K_WR_ENABLE   = 3'h5,
    SEWG_K_WR_DISABLE  = 3'h6
  } sewg_kind_e;

  typedef enum logic [1:0] {
    SEWG_S_IDLE  = 2'h0,
    SEWG_S_SHIFT = 2'h1,
    SEWG_S_WAIT  = 2'h2
  } sewg_state_e;

  // program request handed to the array sequencer
  typedef struct packed {
    sewg_kind_e          kind;
    logic [15:0]         addr;
    logic [DATA_W-1:0]   data;
  } sewg_prog_s;

endpackage : sewg_pkg

// ### rtl/sewg_guard.sv
`timescale 1ns/100ps

// Operation
// - power-up or low supply cancels pending writes and forces program-disable.
// - supply loss mid-programming leaves the target words undefined.
// - write-class frames with any other clock count are cancelled.
// - an overcounted write-disable frame decoding as erase is rejected.
// - no programming starts while chip select is high; host keeps it low idle.
// - serial data output drives high, low, or floats.
// - pulses of 20 ns or less on clock, data, select are filtered.
// - write-enable sets program-enable, write-disable sets program-disable.
// - write, erase, write-all, erase-all run only in program-enable mode.
// - programming starts at select fall; host sends nothing while busy.
module sewg_guard
  import sewg_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
) (
  // system
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  // serial link pins
  input  wire logic        chip_sel_in,
  input  wire logic        ser_clk_in,
  input  wire logic        ser_din_in,
  output logic             ser_dout_out,
  output logic             ser_dout_oe_out,
  // supply monitor, high while the supply is below release level
  input  wire logic        low_supply_in,
  // array sequencer
  input  wire logic        prog_busy_in,
  output logic             prog_start_out,
  output sewg_prog_s       prog_req_out,
  output logic             prog_abort_out,
  output logic             prog_enabled_out
);

  localparam int CNT_W   = 6;
  localparam int SHORT_N = 1 + OP_W + ADDR_W;
  localparam int LONG_N  = SHORT_N + DATA_W;
  localparam logic [CNT_W-1:0] CNT_SHORT = CNT_W'(SHORT_N);
  localparam logic [CNT_W-1:0] CNT_LONG  = CNT_W'(LONG_N);
  localparam logic [CNT_W-1:0] CNT_SAT   = CNT_W'(LONG_N + 1);
  localparam logic [3:0]       FILT_MAX  = 4'(GLITCH_CYC);

  // ****************************************************************
  // input synchronisers and glitch filters
  // ****************************************************************
  logic [2:0] raw;
  logic [2:0] sync1_q, sync2_q, sync3_q;
  logic [2:0] filt_q, filt_d;
  logic [3:0] fcnt_q [3];
  logic [3:0] fcnt_d [3];
  logic [1:0] lvd_sync_q;
  logic       lvd_q;

  assign raw = {chip_sel_in, ser_clk_in, ser_din_in};

  // a level is taken once stage two and three agree; that alone rejects a one-cycle glitch,
  // so each further cycle of glitch width adds one cycle of hold, and a two-cycle pulse still passes
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      filt_d[i] = filt_q[i];
      fcnt_d[i] = 4'h0;
      if (sync2_q[i] == sync3_q[i] && sync3_q[i] != filt_q[i]) begin
        if (fcnt_q[i] >= FILT_MAX - 4'h1) begin
          filt_d[i] = sync3_q[i];
        end else begin
          fcnt_d[i] = fcnt_q[i] + 4'h1;
        end
      end
    end
  end

  // filter registers; select resets low so nothing can start before it is seen high
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sync1_q    <= 3'h0;
      sync2_q    <= 3'h0;
      sync3_q    <= 3'h0;
      filt_q     <= 3'h0;
      lvd_sync_q <= 2'h3;
      lvd_q      <= 1'b1;
      for (int i = 0; i < 3; i++) fcnt_q[i] <= 4'h0;
    end else begin
      sync1_q    <= raw;
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      filt_q     <= filt_d;
      lvd_sync_q <= {lvd_sync_q[0], low_supply_in};
      lvd_q      <= lvd_sync_q[1];
      for (int i = 0; i < 3; i++) fcnt_q[i] <= fcnt_d[i];
    end
  end

  logic cs_f, sk_f, di_f;
  logic cs_prev_q, sk_prev_q;
  logic sk_rise, cs_rise, cs_fall, low_v;

  assign cs_f    = filt_q[2];
  assign sk_f    = filt_q[1];
  assign di_f    = filt_q[0];
  assign sk_rise = sk_f & ~sk_prev_q;
  assign cs_rise = cs_f & ~cs_prev_q;
  assign cs_fall = ~cs_f & cs_prev_q;
  // low supply counts only when both late stages agree
  assign low_v   = lvd_sync_q[1] & lvd_q;

  // ****************************************************************
  // frame decoder and clock-count monitor
  // ****************************************************************
  sewg_state_e             st_q, st_d;
  logic [CNT_W-1:0]        cnt_q, cnt_d;
  logic [OP_W-1:0]         op_q, op_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic [DATA_W-1:0]       data_q, data_d;
  logic                    pe_q, pe_d;
  logic                    start_d;
  sewg_prog_s              req_q, req_d;
  sewg_kind_e              kind;
  logic                    start_q, abort_q, abort_d;

  // classify the captured frame from opcode and top address bits
  function automatic sewg_kind_e decode(input logic [OP_W-1:0] op, input logic [1:0] ext);
    case (op)
      OP_WRITE: decode = SEWG_K_WRITE;
      OP_ERASE: decode = SEWG_K_ERASE;
      OP_EXT: begin
        case (ext)
          EXT_WRITE_ENABLE:  decode = SEWG_K_WR_ENABLE;
          EXT_WRITE_DISABLE: decode = SEWG_K_WR_DISABLE;
          EXT_WRITE_ALL:     decode = SEWG_K_WRITE_ALL;
          EXT_ERASE_ALL:     decode = SEWG_K_ERASE_ALL;
          default:           decode = SEWG_K_NONE;
        endcase
      end
      default: decode = SEWG_K_NONE;
    endcase
  endfunction : decode

  // exact clock count that each write-class or mode frame must carry
  function automatic logic [CNT_W-1:0] expected(input sewg_kind_e k);
    case (k)
      SEWG_K_WRITE, SEWG_K_WRITE_ALL: expected = CNT_LONG;
      default:                        expected = CNT_SHORT;
    endcase
  endfunction : expected

  assign kind = decode(op_q, addr_q[ADDR_W-1 -: 2]);

  // frame tracking, mode flag and program launch
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    op_d    = op_q;
    addr_d  = addr_q;
    data_d  = data_q;
    pe_d    = pe_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    req_d   = req_q;
    case (st_q)
      SEWG_S_IDLE: begin
        // frames arriving while the array is busy are ignored
        if (cs_rise && !prog_busy_in) begin
          st_d  = SEWG_S_SHIFT;
          cnt_d = '0;
        end
      end
      SEWG_S_SHIFT: begin
        if (!cs_f) begin
          st_d = SEWG_S_IDLE;
        end else if (sk_rise && di_f) begin
          st_d  = SEWG_S_WAIT;                       // start bit seen
          cnt_d = CNT_W'(1);
        end
      end
      SEWG_S_WAIT: begin
        if (sk_rise && cnt_q != CNT_SAT) begin
          // overcount saturates above the longest frame and can never match
          cnt_d = cnt_q + CNT_W'(1);
          if (cnt_q <= CNT_W'(OP_W)) begin
            op_d = {op_q[OP_W-2:0], di_f};
          end else if (cnt_q <= CNT_W'(OP_W + ADDR_W)) begin
            addr_d = {addr_q[ADDR_W-2:0], di_f};
          end else begin
            data_d = {data_q[DATA_W-2:0], di_f};
          end
        end
        if (cs_fall) begin
          st_d = SEWG_S_IDLE;
          // wrong count cancels the frame, e.g. an extra clock turning disable into erase
          if (cnt_q == expected(kind) && !low_v) begin
            case (kind)
              SEWG_K_WR_ENABLE:  pe_d = 1'b1;
              SEWG_K_WR_DISABLE: pe_d = 1'b0;
              SEWG_K_WRITE, SEWG_K_ERASE, SEWG_K_WRITE_ALL, SEWG_K_ERASE_ALL: begin
                if (pe_q) begin
                  start_d    = 1'b1;
                  req_d.kind = kind;
                  req_d.addr = 16'(addr_q);
                  req_d.data = (kind == SEWG_K_ERASE || kind == SEWG_K_ERASE_ALL) ? 16'hFFFF : data_q;
                end
              end
              default: ;
            endcase
          end
        end
      end
      default: st_d = SEWG_S_IDLE;
    endcase
    // low supply drops any frame in flight and forces program-disable
    if (low_v) begin
      st_d  = SEWG_S_IDLE;
      pe_d  = 1'b0;
      // contents under programming are undefined; tell the sequencer to stop
      abort_d = prog_busy_in;
    end
  end

  // decoder registers; reset stands for power-up and leaves program-disable
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_q      <= SEWG_S_IDLE;
      cnt_q     <= '0;
      op_q      <= '0;
      addr_q    <= '0;
      data_q    <= '0;
      pe_q      <= 1'b0;
      start_q   <= 1'b0;
      abort_q   <= 1'b0;
      req_q     <= '0;
      cs_prev_q <= 1'b0;
      sk_prev_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      op_q      <= op_d;
      addr_q    <= addr_d;
      data_q    <= data_d;
      pe_q      <= pe_d;
      start_q   <= start_d;
      abort_q   <= abort_d;
      req_q     <= req_d;
      cs_prev_q <= cs_f;
      sk_prev_q <= sk_f;
    end
  end

  // ****************************************************************
  // three-state data output
  // ****************************************************************
  logic dout_q, dout_d, oe_q, oe_d;

  // status shows ready/busy while select is high before a start bit, and also while a
  // frame is ignored because the array is busy, so the host can poll; floats otherwise
  always_comb begin
    oe_d   = 1'b0;
    dout_d = 1'b0;
    if (cs_f && st_q != SEWG_S_WAIT) begin
      oe_d   = 1'b1;
      dout_d = ~prog_busy_in;
    end
  end

  // output registers
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      dout_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_q   <= oe_d;
    end
  end

  assign ser_dout_out     = dout_q;
  assign ser_dout_oe_out  = oe_q;
  assign prog_start_out   = start_q;
  assign prog_req_out     = req_q;
  assign prog_abort_out   = abort_q;
  assign prog_enabled_out = pe_q;

endmodule : sewg_guard

// ### verif/sewg_guard_properties.sv
`timescale 1ns/100ps

// ****************************************
// link guard checks
// ****************************************
module sewg_guard_properties
  import sewg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // system
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  // link pins
  input wire logic       chip_sel_in,
  input wire logic       ser_clk_in,
  input wire logic       ser_din_in,
  input wire logic       ser_dout_out,
  input wire logic       ser_dout_oe_out,
  input wire logic       low_supply_in,
  // array side
  input wire logic       prog_busy_in,
  input wire logic       prog_start_out,
  input wire sewg_prog_s prog_req_out,
  input wire logic       prog_abort_out,
  input wire logic       prog_enabled_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // one-cycle select blip after a quiet spell, too short to pass the filter
  sequence cs_quiet_s; !chip_sel_in [*8]; endsequence
  sequence cs_blip_s; chip_sel_in ##1 !chip_sel_in; endsequence

  AST_BLIP_IGNORED: assert property (cs_quiet_s ##1 cs_blip_s |-> !ser_dout_oe_out [*6])
    else $error("select blip woke the output");
  AST_LOW_SUPPLY_LOCK: assert property (low_supply_in [*6] |-> !prog_enabled_out && !prog_start_out)
    else $error("low supply left writes open");
  AST_START_NEEDS_MODE: assert property (prog_start_out |-> prog_enabled_out && $past(prog_enabled_out))
    else $error("start outside program-enable");
  AST_START_AFTER_CS: assert property (prog_start_out |-> !chip_sel_in && !$past(chip_sel_in, 3))
    else $error("start while select high");
  AST_START_PULSE: assert property (prog_start_out |=> !prog_start_out)
    else $error("start longer than one cycle");
  AST_REQ_HOLDS: assert property (!prog_start_out |-> $stable(prog_req_out))
    else $error("request changed without start");
  // low select must float the output once the filter has settled
  AST_FLOAT_CS_LOW: assert property (!chip_sel_in [*8] |-> !ser_dout_oe_out)
    else $error("output driven with select low");
  AST_READY_LEVEL: assert property (ser_dout_oe_out && $past(ser_dout_oe_out) |-> ser_dout_out == !$past(prog_busy_in))
    else $error("output not ready level");
  AST_MODE_AT_CS_FALL: assert property ($rose(prog_enabled_out) |-> !chip_sel_in && !low_supply_in)
    else $error("mode set outside frame end");
endmodule : sewg_guard_properties

bind sewg_guard sewg_guard_properties #(.ADDR_W(ADDR_W)) i_sewg_guard_properties (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .chip_sel_in(chip_sel_in),
  .ser_clk_in(ser_clk_in), .ser_din_in(ser_din_in), .ser_dout_out(ser_dout_out),
  .ser_dout_oe_out(ser_dout_oe_out), .low_supply_in(low_supply_in), .prog_busy_in(prog_busy_in),
  .prog_start_out(prog_start_out), .prog_req_out(prog_req_out), .prog_abort_out(prog_abort_out),
  .prog_enabled_out(prog_enabled_out)
);

// ### verif/sewg_host_model.sv
`timescale 1ns/100ps

// ****************************************
// host side of the serial link
// ****************************************
module sewg_host_model (
  // clock
  input  wire logic clk_in,
  // link pins
  output logic      cs_out,
  output logic      sk_out,
  output logic      di_out
);
  // select idles low so nothing can program between frames
  initial begin
    cs_out = 1'b0;
    sk_out = 1'b0;
    di_out = 1'b0;
  end

  // n clock rises, bits msb first from b[n-1]; 160 ns link period
  task automatic send(input logic [27:0] b, input int n);
    @(posedge clk_in) cs_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    for (int i = n - 1; i >= 0; i--) begin
      di_out <= b[i];
      repeat (4) @(posedge clk_in);
      sk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sk_out <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    cs_out <= 1'b0;
    di_out <= ~di_out; // stale data line shows the inverse
    // clock stands still while the array programs
    repeat (12) @(posedge clk_in);
  endtask : send

  task automatic set_cs(input logic v);
    @(posedge clk_in) cs_out <= v;
  endtask : set_cs
endmodule : sewg_host_model

// ### verif/tb_top.sv
`timescale 1ns/100ps

// ****************************************
// guard testbench
// ****************************************
module tb_top;
  import sewg_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        low_supply_in = 1'b0;
  logic        prog_busy_in = 1'b0;
  wire logic   chip_sel_in;
  wire logic   ser_clk_in;
  wire logic   ser_din_in;
  logic        ser_dout_out;
  logic        ser_dout_oe_out;
  logic        prog_start_out;
  logic        prog_abort_out;
  logic        prog_enabled_out;
  sewg_prog_s  prog_req_out;
  sewg_prog_s  last_req_q;
  int          num_errors = 0;
  int          check_count = 0;
  int          starts = 0;
  int          cyc = 0;
  localparam logic [27:0] ENA = 28'({1'b1, OP_EXT, EXT_WRITE_ENABLE, 6'h00});
  localparam logic [27:0] DIS = 28'({1'b1, OP_EXT, EXT_WRITE_DISABLE, 6'h00});
  localparam logic [27:0] FR [4] = '{28'({1'b1, OP_WRITE, 8'hA5, 16'h1234}), 28'({1'b1, OP_ERASE, 8'h3C}),
    28'({1'b1, OP_EXT, EXT_WRITE_ALL, 6'h00, 16'h5A5A}), 28'({1'b1, OP_EXT, EXT_ERASE_ALL, 6'h00})};
  localparam int NB [4] = '{27, 11, 27, 11};
  localparam sewg_kind_e KD [4] = '{SEWG_K_WRITE, SEWG_K_ERASE, SEWG_K_WRITE_ALL, SEWG_K_ERASE_ALL};
  localparam logic [15:0] DT [4] = '{16'h1234, 16'hFFFF, 16'h5A5A, 16'hFFFF};
  localparam logic [15:0] AD [4] = '{16'h00A5, 16'h003C, 16'h0040, 16'h0080};

  initial forever #10 sys_clk_in = ~sys_clk_in;

  sewg_host_model i_sewg_host_model (.clk_in(sys_clk_in), .cs_out(chip_sel_in), .sk_out(ser_clk_in),
    .di_out(ser_din_in));
  sewg_guard i_sewg_guard (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .chip_sel_in(chip_sel_in),
    .ser_clk_in(ser_clk_in), .ser_din_in(ser_din_in), .ser_dout_out(ser_dout_out),
    .ser_dout_oe_out(ser_dout_oe_out), .low_supply_in(low_supply_in), .prog_busy_in(prog_busy_in),
    .prog_start_out(prog_start_out), .prog_req_out(prog_req_out), .prog_abort_out(prog_abort_out),
    .prog_enabled_out(prog_enabled_out));

  // count launches and cut a hang short
  always @(posedge sys_clk_in) begin
    cyc++;
    if (prog_start_out === 1'b1) begin
      starts++;
      last_req_q = prog_req_out;
    end
    if (cyc == 10000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic t_mode;
    int s = starts;
    i_sewg_host_model.send(FR[0], 27);
    chk(starts == s, "write in disable mode");
    i_sewg_host_model.send(ENA, 11);
    chk(prog_enabled_out === 1'b1, "enable");
    i_sewg_host_model.send(DIS, 11);
    chk(prog_enabled_out === 1'b0, "disable");
    i_sewg_host_model.send(FR[1], 11);
    chk(starts == s, "erase in disable mode");
  endtask : t_mode

  task automatic t_kinds;
    int s;
    i_sewg_host_model.send(ENA, 11);
    for (int i = 0; i < 4; i++) begin
      s = starts;
      i_sewg_host_model.send(FR[i], NB[i]);
      chk(starts == s + 1 && last_req_q.kind === KD[i] && last_req_q.data === DT[i] &&
          last_req_q.addr === AD[i], "launch");
    end
    chk(prog_req_out === last_req_q && prog_start_out === 1'b0, "request not held");
  endtask : t_kinds

  task automatic t_count;
    int s = starts;
    i_sewg_host_model.send({FR[0][26:0], 1'b0}, 28);
    chk(starts == s, "overcount write");
    i_sewg_host_model.send(FR[0] >> 1, 26);
    chk(starts == s, "undercount write");
    i_sewg_host_model.send(28'({1'b1, OP_ERASE, 8'h00, 1'b0}), 12);
    chk(starts == s && prog_enabled_out === 1'b1, "overcount erase");
    i_sewg_host_model.send(28'({1'b1, OP_READ, 8'h00}), 11);
    chk(starts == s && prog_enabled_out === 1'b1, "read frame launched");
    i_sewg_host_model.send(FR[0], 27);
    chk(starts == s + 1, "exact count after bad frames");
  endtask : t_count

  task automatic t_busy;
    int s = starts;
    @(posedge sys_clk_in) prog_busy_in <= 1'b1;
    i_sewg_host_model.set_cs(1'b1);
    repeat (8) @(posedge sys_clk_in);
    chk(ser_dout_oe_out === 1'b1 && ser_dout_out === 1'b0, "busy level");
    prog_busy_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk(ser_dout_out === 1'b1, "ready level");
    i_sewg_host_model.set_cs(1'b0);
    repeat (10) @(posedge sys_clk_in);
    chk(ser_dout_oe_out === 1'b0, "float");
    prog_busy_in <= 1'b1;
    i_sewg_host_model.send(FR[0], 27);
    chk(starts == s, "frame while busy");
    prog_busy_in <= 1'b0;
  endtask : t_busy

  task automatic t_low;
    int s;
    @(posedge sys_clk_in) prog_busy_in <= 1'b1;
    low_supply_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    chk(prog_abort_out === 1'b1 && prog_enabled_out === 1'b0, "supply loss");
    prog_busy_in <= 1'b0;
    i_sewg_host_model.send(ENA, 11);
    chk(prog_enabled_out === 1'b0, "enable while low");
    low_supply_in <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    s = starts;
    i_sewg_host_model.send(FR[0], 27);
    chk(starts == s, "write before re-enable");
    i_sewg_host_model.send(ENA, 11);
    i_sewg_host_model.send(FR[0], 27);
    chk(starts == s + 1, "write after re-enable");
    i_sewg_host_model.set_cs(1'b1);
    i_sewg_host_model.set_cs(1'b0);
    repeat (6) @(posedge sys_clk_in);
    chk(ser_dout_oe_out === 1'b0, "blip");
  endtask : t_low

  task automatic complete_run;
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    t_mode();
    t_kinds();
    t_count();
    t_busy();
    t_low();
    complete_run();
  end
endmodule : tb_top
